// >>> hw/dual_counter_pwm_timer.sv
// Dual 12-bit counter PWM timer: duty, capture, break enables, counter 2, dead time
`timescale 1ns/10ps
`default_nettype none

module dual_counter_pwm_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic counter_tick,
   input wire logic [11:0] main_reload,
   input wire logic timer_capture_pin,
   input wire logic lite_capture_pin,
   input wire logic [3:0] pwm_pin_enable,
   input wire logic [3:0] polarity_preload,
   input wire logic break_active,
   input wire logic [3:0] break_pattern,
   output logic [3:0] pwm_out,
   output logic second_wrap_irq,
   output logic capture_flag,
   output logic [11:0] main_counter
);
   localparam int NCH = pwm_timer_pkg::NCH;

   logic [11:0] c1_q;
   logic [11:0] c2_q;
   logic [11:0] rld2_q;
   logic [11:0] cap_q;
   logic [7:0] ctrl2_q;
   logic [7:0] gap_q;
   logic [1:0] brk_en_q;
   logic capf_q;
   logic pin_prev_q;
   logic wrap1_q;
   logic wrap2_q;
   logic irq_q;
   logic ref_prev_q;
   logic [6:0] dt_cnt_q;
   logic [3:0] pwm_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [NCH-1:0][11:0] duty_pre_q;
   logic [NCH-1:0][11:0] duty_act_q;
   logic [NCH-1:0] pol_act_q;

   // APB decode; one wait state so read data comes from a flop
   wire [5:0] idx = paddr[7:2];
   wire acc_first = psel & penable & ~pready_q;
   wire done = psel & penable & pready_q;
   wire wr = done & pwrite;
   wire rd = done & ~pwrite;
   wire [7:0] wb = pwdata[7:0];
   wire [NCH-1:0] hit_hi;
   wire [NCH-1:0] hit_lo;
   wire hit_cap_hi = idx == pwm_timer_pkg::IDX_CAP_HI;
   wire hit_cap_lo = idx == pwm_timer_pkg::IDX_CAP_LO;
   wire hit_ctrl2 = idx == pwm_timer_pkg::IDX_CTRL2;
   wire hit_rld_hi = idx == pwm_timer_pkg::IDX_RLD2_HI;
   wire hit_rld_lo = idx == pwm_timer_pkg::IDX_RLD2_LO;
   wire hit_gap = idx == pwm_timer_pkg::IDX_GAP;
   wire hit_brk = idx == pwm_timer_pkg::IDX_BRK_EN;
   wire hit_stat = idx == pwm_timer_pkg::IDX_STATUS;
   wire mapped = (|hit_hi) | (|hit_lo) | hit_cap_hi | hit_cap_lo | hit_ctrl2 | hit_rld_hi
      | hit_rld_lo | hit_gap | hit_brk | hit_stat;
   wire wr_ctrl2 = wr & hit_ctrl2;

   // Control bit views
   wire force_second_wrap = ctrl2_q[pwm_timer_pkg::B_FORCE_SECOND_WRAP];
   wire force_main_wrap = ctrl2_q[pwm_timer_pkg::B_FORCE_MAIN_WRAP];
   wire capture_pin_select = ctrl2_q[pwm_timer_pkg::B_ICS];
   wire second_wrap_irq_enable = ctrl2_q[pwm_timer_pkg::B_SECOND_WRAP_IRQ_ENABLE];
   wire second_wrap_flag = ctrl2_q[pwm_timer_pkg::B_SECOND_WRAP_FLAG];
   wire sel2 = ctrl2_q[pwm_timer_pkg::B_SEL];
   wire second_transfer_enable = ctrl2_q[pwm_timer_pkg::B_SECOND_TRANSFER_ENABLE];
   wire main_transfer_enable = ctrl2_q[pwm_timer_pkg::B_MAIN_TRANSFER_ENABLE];
   wire gap_en = gap_q[pwm_timer_pkg::B_GAP_EN];
   wire [6:0] gap_len = gap_q[6:0];

   // Counters
   wire f1_set = wr_ctrl2 & wb[pwm_timer_pkg::B_FORCE_MAIN_WRAP];
   wire f2_set = wr_ctrl2 & wb[pwm_timer_pkg::B_FORCE_SECOND_WRAP];
   wire tick2 = counter_tick & sel2;
   wire wrap1 = counter_tick & (c1_q == pwm_timer_pkg::CNT_TOP);
   wire wrap2 = tick2 & (c2_q == pwm_timer_pkg::CNT_TOP);
   wire xfer1 = wrap1 & main_transfer_enable;
   wire xfer2 = wrap2 & second_transfer_enable;
   wire [11:0] c1_d = f1_set ? pwm_timer_pkg::CNT_TOP :
      wrap1 ? main_reload : c1_q + 12'h001;
   wire [11:0] c2_d = f2_set ? pwm_timer_pkg::CNT_TOP :
      wrap2 ? rld2_q : c2_q + 12'h001;

   // Second control register next value; hardware sets win over clears
   wire force_second_wrap_d = f2_set | (force_second_wrap & ~wrap2_q);
   wire force_main_wrap_d = f1_set | (force_main_wrap & ~wrap1_q);
   wire second_wrap_flag_d = wrap2 | (second_wrap_flag & ~(rd & hit_ctrl2));
   wire second_transfer_enable_d = (wr_ctrl2 & wb[pwm_timer_pkg::B_SECOND_TRANSFER_ENABLE]) | (second_transfer_enable & ~(xfer2 & sel2));
   wire main_transfer_enable_d = (wr_ctrl2 & wb[pwm_timer_pkg::B_MAIN_TRANSFER_ENABLE]) | (main_transfer_enable & ~xfer1);
   wire ics_d = wr_ctrl2 ? wb[pwm_timer_pkg::B_ICS] : capture_pin_select;
   wire second_wrap_irq_enable_d = wr_ctrl2 ? wb[pwm_timer_pkg::B_SECOND_WRAP_IRQ_ENABLE] : second_wrap_irq_enable;
   wire sel2_d = wr_ctrl2 ? wb[pwm_timer_pkg::B_SEL] : sel2;
   wire [7:0] ctrl2_d = {force_second_wrap_d, force_main_wrap_d, ics_d, second_wrap_irq_enable_d, second_wrap_flag_d, sel2_d, second_transfer_enable_d, main_transfer_enable_d};

   // Capture; changing the source select can itself look like an edge
   wire cap_pin = capture_pin_select ? lite_capture_pin : timer_capture_pin;
   wire cap_edge = cap_pin ^ pin_prev_q;
   wire cap_take = cap_edge & ~capf_q;
   wire cap_read = rd & (hit_cap_hi | hit_cap_lo);
   wire capf_d = cap_take | (capf_q & ~cap_read);

   // Per channel duty path
   wire [NCH-1:0] raw;
   wire [NCH-1:0] load;
   logic [31:0] duty_rd;
   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch++)
      begin : g_ch
         wire on_c2 = (ch >= 2) & sel2;
         wire [11:0] cnt = on_c2 ? c2_q : c1_q;
         assign hit_hi[ch] = idx == 6'(pwm_timer_pkg::IDX_DUTY0_HI + 2 * ch);
         assign hit_lo[ch] = idx == 6'(pwm_timer_pkg::IDX_DUTY0_LO + 2 * ch);
         assign load[ch] = on_c2 ? xfer2 : xfer1;
         // Output high from reload until the counter reaches the duty value
         assign raw[ch] = cnt < duty_act_q[ch];
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               duty_pre_q[ch] <= 12'h000;
               duty_act_q[ch] <= 12'h000;
               pol_act_q[ch] <= 1'b0;
            end
            else
            begin
               if (wr & hit_hi[ch])
                  duty_pre_q[ch][11:8] <= wb[3:0];
               if (wr & hit_lo[ch])
                  duty_pre_q[ch][7:0] <= wb;
               if (load[ch])
               begin
                  duty_act_q[ch] <= duty_pre_q[ch];
                  pol_act_q[ch] <= polarity_preload[ch];
               end
            end
         end
      end
   endgenerate

   always_comb
   begin
      duty_rd = 32'h0000_0000;
      for (int i = 0; i < NCH; i++)
      begin
         if (hit_hi[i])
            duty_rd = {28'h000_0000, duty_pre_q[i][11:8]};
         if (hit_lo[i])
            duty_rd = {24'h00_0000, duty_pre_q[i][7:0]};
      end
   end

   // Read mux; reserved bits stay zero
   wire [31:0] rd_w = (|hit_hi) | (|hit_lo) ? duty_rd :
      hit_cap_hi ? {28'h000_0000, cap_q[11:8]} :
      hit_cap_lo ? {24'h00_0000, cap_q[7:0]} :
      hit_ctrl2 ? {24'h00_0000, ctrl2_q} :
      hit_rld_hi ? {28'h000_0000, rld2_q[11:8]} :
      hit_rld_lo ? {24'h00_0000, rld2_q[7:0]} :
      hit_gap ? {24'h00_0000, gap_q} :
      hit_brk ? {30'h0000_0000, brk_en_q} :
      hit_stat ? {19'h0_0000, capf_q, c1_q} : 32'h0000_0000;

   // Limitation: the gap is counted in main ticks, so it stretches with the tick rate
   // Dead time: PWM0 reference split into two non-overlapping outputs
   wire ref_chg = raw[0] ^ ref_prev_q;
   wire gap_zero = gap_en & (gap_len == 7'h00);
   wire dt_ok = (dt_cnt_q >= gap_len) & ~ref_chg;
   wire [1:0] gap_out = gap_en ? {~raw[0] & dt_ok, raw[0] & dt_ok} : raw[1:0];
   wire [3:0] shaped = {raw[3:2], gap_out} ^ pol_act_q;

   // Second break enable only matters while PWM2/3 follow the second counter
   // Break routing
   wire brk1 = break_active & brk_en_q[pwm_timer_pkg::B_BREAK_ENABLE_FIRST];
   wire brk2 = break_active & brk_en_q[pwm_timer_pkg::B_BREAK_ENABLE_SECOND];
   wire brk23 = sel2 ? brk2 : brk1;
   wire [3:0] brk_ch = {brk23, brk23, brk1, brk1};
   wire [3:0] zero_ch = {2'b00, gap_zero, gap_zero};
   wire [3:0] lvl_on = (brk_ch & break_pattern) | (~brk_ch & ~zero_ch & shaped);
   wire [3:0] pwm_d = pwm_pin_enable & lvl_on;

   // Main counter; a force write wins over a tick in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c1_q <= 12'h000;
      end
      else
      begin
         if (f1_set | counter_tick)
            c1_q <= c1_d;
      end
   end

   // Second counter; ticks are ignored while deselected, but a force write still loads the top value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         c2_q <= 12'h000;
      end
      else
      begin
         if (f2_set | tick2)
            c2_q <= c2_d;
      end
   end

   // Wrap pulses delayed one clock so force bits drop just after the wrap
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wrap1_q <= 1'b0;
         wrap2_q <= 1'b0;
         ctrl2_q <= pwm_timer_pkg::CTRL2_RST;
      end
      else
      begin
         wrap1_q <= wrap1;
         wrap2_q <= wrap2;
         ctrl2_q <= ctrl2_d;
      end
   end

   // Reload bytes stored at once; no ordering between the two writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rld2_q <= 12'h000;
      end
      else
      begin
         if (wr & hit_rld_hi)
            rld2_q[11:8] <= wb[3:0];
         if (wr & hit_rld_lo)
            rld2_q[7:0] <= wb;
      end
   end

   // Break enables (bits 1:0 only) and gap setting (full byte) are plain read/write registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_q <= pwm_timer_pkg::GAP_RST;
         brk_en_q <= pwm_timer_pkg::BRK_EN_RST;
      end
      else
      begin
         if (wr & hit_gap)
            gap_q <= wb;
         if (wr & hit_brk)
            brk_en_q <= wb[1:0];
      end
   end

   // Capture edge is taken against the last sampled pin level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_q <= 12'h000;
         capf_q <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else
      begin
         pin_prev_q <= cap_pin;
         capf_q <= capf_d;
         if (cap_take)
            cap_q <= c1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ref_prev_q <= 1'b0;
         dt_cnt_q <= 7'h00;
      end
      else
      begin
         ref_prev_q <= raw[0];
         // A tick landing on the change edge is the first tick of the gap
         if (ref_chg)
            dt_cnt_q <= {6'h00, counter_tick};
         else if (counter_tick & (dt_cnt_q < gap_len))
            dt_cnt_q <= dt_cnt_q + 7'h01;
      end
   end

   // Pins and interrupt come straight from flops, one clock behind the logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwm_q <= 4'h0;
         irq_q <= 1'b0;
      end
      else
      begin
         pwm_q <= pwm_d;
         irq_q <= second_wrap_flag & second_wrap_irq_enable;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= acc_first;
         pslverr_q <= acc_first & ~mapped;
         if (acc_first & ~pwrite)
            prdata_q <= rd_w;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pwm_out = pwm_q;
   assign second_wrap_irq = irq_q;
   assign capture_flag = capf_q;
   assign main_counter = c1_q;
endmodule // dual_counter_pwm_timer

`default_nettype wire

// >>> hw/pwm_timer_pkg.sv
// Constants for the dual counter PWM timer
package pwm_timer_pkg;
   localparam int CW = 12;
   localparam int NCH = 4;
   localparam logic [11:0] CNT_TOP = 12'hFFF;
   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_DUTY0_HI = 6'h17;
   localparam logic [5:0] IDX_DUTY0_LO = 6'h18;
   localparam logic [5:0] IDX_CAP_HI = 6'h1F;
   localparam logic [5:0] IDX_CAP_LO = 6'h20;
   localparam logic [5:0] IDX_CTRL2 = 6'h21;
   localparam logic [5:0] IDX_RLD2_HI = 6'h23;
   localparam logic [5:0] IDX_RLD2_LO = 6'h24;
   localparam logic [5:0] IDX_GAP = 6'h25;
   localparam logic [5:0] IDX_BRK_EN = 6'h26;
   localparam logic [5:0] IDX_STATUS = 6'h27;
   // second_timer_control fields
   localparam int B_FORCE_SECOND_WRAP = 7;
   localparam int B_FORCE_MAIN_WRAP = 6;
   localparam int B_ICS = 5;
   localparam int B_SECOND_WRAP_IRQ_ENABLE = 4;
   localparam int B_SECOND_WRAP_FLAG = 3;
   localparam int B_SEL = 2;
   localparam int B_SECOND_TRANSFER_ENABLE = 1;
   localparam int B_MAIN_TRANSFER_ENABLE = 0;
   // gap_generator_control and break_enable_control fields
   localparam int B_GAP_EN = 7;
   localparam int B_BREAK_ENABLE_SECOND = 1;
   localparam int B_BREAK_ENABLE_FIRST = 0;
   // status register fields
   localparam int B_STAT_CAPF = 12;
   localparam logic [7:0] CTRL2_RST = 8'h03;
   localparam logic [7:0] GAP_RST = 8'h00;
   localparam logic [1:0] BRK_EN_RST = 2'h3;
endpackage

// >>> verification/dual_counter_pwm_timer_assertions.sv
// Port checks for the dual counter PWM timer
`timescale 1ns/10ps
`default_nettype none
module pwm_timer_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic counter_tick,
   input wire logic [11:0] main_reload,
   input wire logic timer_capture_pin,
   input wire logic lite_capture_pin,
   input wire logic [3:0] pwm_pin_enable,
   input wire logic [3:0] pwm_out,
   input wire logic capture_flag,
   input wire logic [11:0] main_counter
);
   wire logic done = psel && penable && pready;
   wire logic wr_done = done && pwrite;
   wire logic [5:0] idx = paddr[7:2];
   wire logic cap_rd = done && !pwrite && (idx == pwm_timer_pkg::IDX_CAP_HI || idx == pwm_timer_pkg::IDX_CAP_LO);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_unmapped_err: assert property (done && idx > pwm_timer_pkg::IDX_STATUS |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_reserved_zero: assert property (done && !pwrite && idx == pwm_timer_pkg::IDX_BRK_EN |-> prdata[31:2] == 30'h0)
      else $error("reserved bits not zero");
   a_flag_hold: assert property (capture_flag && !cap_rd |=> capture_flag)
      else $error("capture flag dropped without read");
   a_cap_clear: assert property (cap_rd && $stable(timer_capture_pin) && $stable(lite_capture_pin) |=> !capture_flag)
      else $error("capture read left flag set");
   a_count_step: assert property (counter_tick && main_counter != 12'hFFF && !wr_done
      |=> main_counter == $past(main_counter) + 12'h001)
      else $error("counter did not step");
   a_count_wrap: assert property (counter_tick && main_counter == 12'hFFF && !wr_done
      |=> main_counter == $past(main_reload))
      else $error("counter did not reload");
   a_count_hold: assert property (!counter_tick && !wr_done |=> $stable(main_counter))
      else $error("counter moved without tick");
   a_pin_mask: assert property (##1 (pwm_out & ~$past(pwm_pin_enable)) == 4'h0)
      else $error("disabled output driven");
endmodule // pwm_timer_chk
bind dual_counter_pwm_timer pwm_timer_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .counter_tick, .main_reload, .timer_capture_pin, .lite_capture_pin, .pwm_pin_enable,
   .pwm_out, .capture_flag, .main_counter);
`default_nettype wire

// >>> verification/pwm_load_model.sv
// Load model on the PWM pins: high-cycle counters and overlap watch
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
   input wire logic pclk,
   input wire logic clr,
   input wire logic [3:0] pwm_out,
   output logic [12:0] hi0,
   output logic [12:0] hi1,
   output logic overlap
);
   // Both switches of a leg on at once would short the supply
   always_ff @(posedge pclk)
   begin
      hi0 <= clr ? 13'h0 : hi0 + 13'(pwm_out[0]);
      hi1 <= clr ? 13'h0 : hi1 + 13'(pwm_out[1]);
      overlap <= clr ? 1'b0 : overlap | (pwm_out[0] & pwm_out[1]);
   end
endmodule // pwm_load_model
`default_nettype wire

// >>> verification/test_dual_counter_pwm_timer.sv
// Register-level bench for the dual counter PWM timer
`timescale 1ns/10ps
`default_nettype none
module test_dual_counter_pwm_timer;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, counter_tick = 1'b0;
   logic timer_capture_pin = 1'b0, lite_capture_pin = 1'b0, break_active = 1'b0, clr = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] main_reload = 12'h123;
   logic [3:0] pwm_pin_enable = 4'hF, polarity_preload = 4'h0, break_pattern = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, second_wrap_irq, capture_flag, overlap;
   logic [11:0] main_counter;
   logic [3:0] pwm_out;
   logic [12:0] hi0, hi1;
   int err_count = 0, tests_run = 0, cyc = 0;

   always #10 pclk = ~pclk;
   dual_counter_pwm_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .counter_tick, .main_reload, .timer_capture_pin, .lite_capture_pin, .pwm_pin_enable,
      .polarity_preload, .break_active, .break_pattern, .pwm_out, .second_wrap_irq, .capture_flag, .main_counter);
   pwm_load_model load_u (.pclk, .clr, .pwm_out, .hi0, .hi1, .overlap);

   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [31:0] r,
      output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 16)
      begin
         err_count++;
         $display("unexpected at %0t: no ready", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, i, d, r, e);
      repeat (2) @(posedge pclk);
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      xfer(1'b0, i, 8'h00, r, e);
      ck(r, {24'h0, x});
   endtask
   task automatic tk(input int n);
      repeat (n)
      begin
         counter_tick <= 1'b1;
         @(posedge pclk);
         counter_tick <= 1'b0;
         @(posedge pclk);
      end
      repeat (2) @(posedge pclk);
   endtask
   task automatic pin(input logic lite);
      if (lite)
         lite_capture_pin <= ~lite_capture_pin;
      else
         timer_capture_pin <= ~timer_capture_pin;
      repeat (3) @(posedge pclk);
   endtask
   // One full main period is 4096 samples when the reload is zero
   task automatic meas(input logic [12:0] e0, input logic [12:0] e1);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (4097) @(posedge pclk);
      ck(32'(hi0), 32'(e0));
      ck(32'(hi1), 32'(e1));
   endtask
   task conclude;
      $display("errors %0d, checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_count++;
         $display("unexpected at %0t: run hung", $time);
         conclude();
      end
   end

   initial
   begin
      logic [31:0] r;
      logic e;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h03);
      rd(pwm_timer_pkg::IDX_BRK_EN, 8'h03);
      rd(pwm_timer_pkg::IDX_GAP, 8'h00);
      xfer(1'b0, 6'h3F, 8'h00, r, e);
      ck(32'(e), 32'h1);
      wr(pwm_timer_pkg::IDX_RLD2_HI, 8'hFF);
      rd(pwm_timer_pkg::IDX_RLD2_HI, 8'h0F);
      // Capture with the counter parked, so the latched value is known
      wr(pwm_timer_pkg::IDX_CTRL2, 8'h43);
      ck(32'(main_counter), 32'hFFF);
      pin(1'b0);
      ck(32'(capture_flag), 32'h1);
      tk(2);
      ck(32'(main_counter), 32'h124);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h02);
      pin(1'b0);
      rd(pwm_timer_pkg::IDX_CAP_HI, 8'h0F);
      ck(32'(capture_flag), 32'h0);
      rd(pwm_timer_pkg::IDX_CAP_LO, 8'hFF);
      pin(1'b1);
      pin(1'b1);
      ck(32'(capture_flag), 32'h0);
      wr(pwm_timer_pkg::IDX_CTRL2, 8'h22);
      pin(1'b1);
      rd(pwm_timer_pkg::IDX_CAP_LO, 8'h24);
      // Second counter: forced wrap, reload, freeze and resume
      wr(pwm_timer_pkg::IDX_RLD2_LO, 8'hFD);
      wr(pwm_timer_pkg::IDX_CTRL2, 8'hB6);
      tk(1);
      ck(32'(second_wrap_irq), 32'h1);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h3C);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h34);
      ck(32'(second_wrap_irq), 32'h0);
      tk(2);
      ck(32'(second_wrap_irq), 32'h0);
      tk(1);
      ck(32'(second_wrap_irq), 32'h1);
      wr(pwm_timer_pkg::IDX_CTRL2, 8'h30);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h38);
      tk(3);
      ck(32'(second_wrap_irq), 32'h0);
      wr(pwm_timer_pkg::IDX_CTRL2, 8'h34);
      tk(3);
      ck(32'(second_wrap_irq), 32'h1);
      rd(pwm_timer_pkg::IDX_CTRL2, 8'h3C);
      // Duty transfer at the forced wrap, then dead time
      main_reload <= 12'h000;
      wr(pwm_timer_pkg::IDX_DUTY0_LO, 8'h02);
      wr(pwm_timer_pkg::IDX_CTRL2, 8'h65);
      counter_tick <= 1'b1;
      meas(13'd2, 13'd0);
      wr(pwm_timer_pkg::IDX_GAP, 8'h81);
      meas(13'd1, 13'd4093);
      ck(32'(overlap), 32'h0);
      wr(pwm_timer_pkg::IDX_GAP, 8'h80);
      meas(13'd0, 13'd0);
      wr(pwm_timer_pkg::IDX_GAP, 8'h00);
      counter_tick <= 1'b0;
      break_active <= 1'b1;
      break_pattern <= 4'hF;
      repeat (3) @(posedge pclk);
      ck(32'(pwm_out), 32'hF);
      wr(pwm_timer_pkg::IDX_BRK_EN, 8'h02);
      ck(32'(pwm_out[2:1]), 32'h2);
      wr(pwm_timer_pkg::IDX_BRK_EN, 8'h01);
      ck(32'(pwm_out[3:1]), 32'h1);
      conclude();
   end
endmodule // test_dual_counter_pwm_timer
`default_nettype wire
